// ### rtl/rals_regs.vh
`ifndef RALS_REGS_VH
`define RALS_REGS_VH

// register offsets
`define RALS_OFS_CRC_CTRL 8'h04
`define RALS_OFS_TARGET 8'h07
`define RALS_OFS_ALIAS 8'h08
`define RALS_OFS_CRC_LOW 8'h0A
`define RALS_OFS_CRC_HIGH 8'h0B
`define RALS_OFS_STATUS 8'h0C

// field positions
`define RALS_CRC_RESET_BIT 5
`define RALS_ADDR_MSB 7
`define RALS_ADDR_LSB 1
`define RALS_ST_LINK_DETECT 0
`define RALS_ST_DES_ERROR 1
`define RALS_ST_CLOCK_PRESENT 2
`define RALS_ST_SELFTEST_ERR 3
`define RALS_ST_LINK_LOST 4

// reset values
`define RALS_RST_BYTE 8'h00
`define RALS_RST_ADDR 7'h00
`define RALS_RST_COUNT 16'h0000

`endif

// ### rtl/rals_port_status.v
`timescale 1ns/1ps
`default_nettype none
`include "rals_regs.vh"
// per-port back-channel health: counter and sticky flags
module rals_port_status (
  // clock and reset
  input wire ref_clk_i,
  input wire rst_n_i,
  // link events
  input wire link_detect_i,
  input wire crc_err_i,
  input wire bist_run_i,
  input wire bist_start_i,
  // software clear, level
  input wire crc_clear_i,
  // state
  output reg [15:0] crc_count_o,
  output reg link_lost_o,
  output reg selftest_err_o,
  output reg des_err_o
);

  reg link_seen;
  wire lost_evt;
  wire count_full;

  // loss is the falling edge of detect
  assign lost_evt = link_seen & ~link_detect_i;
  assign count_full = &crc_count_o;

  // delayed detect for edge finding
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      link_seen <= 1'b0;
    end else begin
      link_seen <= link_detect_i;
    end
  end

  // counter: clear, then saturate instead of wrapping
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      crc_count_o <= `RALS_RST_COUNT;
    end else if (crc_clear_i) begin
      crc_count_o <= {15'h0000, crc_err_i};
    end else if (crc_err_i && !count_full) begin
      crc_count_o <= crc_count_o + 16'h0001;
    end
  end

  // sticky flags; a new event wins over any clear in the same cycle
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      link_lost_o <= 1'b0;
      selftest_err_o <= 1'b0;
      des_err_o <= 1'b0;
    end else begin
      if (lost_evt) begin
        link_lost_o <= 1'b1;
      end else if (crc_clear_i) begin
        link_lost_o <= 1'b0;
      end
      if (crc_err_i && bist_run_i) begin
        selftest_err_o <= 1'b1;
      end else if (lost_evt || bist_start_i || crc_clear_i) begin
        selftest_err_o <= 1'b0;
      end
      if (crc_err_i && !bist_run_i) begin
        des_err_o <= 1'b1;
      end else if (lost_evt || crc_clear_i) begin
        des_err_o <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ### rtl/rals_alias_match.v
`timescale 1ns/1ps
`default_nettype none
`include "rals_regs.vh"
// alias lookup over both ports; port 0 wins if both match
module rals_alias_match (
  // clock and reset
  input wire ref_clk_i,
  input wire rst_n_i,
  // tables, port 1 in the upper half
  input wire [13:0] alias_tab_i,
  input wire [13:0] target_tab_i,
  // local request
  input wire loc_req_i,
  input wire [6:0] loc_addr_i,
  // forwarded request
  output reg fwd_req_o,
  output reg [6:0] fwd_addr_o,
  output reg fwd_port_o
);

  wire [1:0] hit;

  // a zero alias or target disables the entry entirely
  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1) begin : g_hit
      assign hit[p] = loc_req_i && (alias_tab_i[p*7 +: 7] == loc_addr_i) &&
                      (alias_tab_i[p*7 +: 7] != `RALS_RST_ADDR) &&
                      (target_tab_i[p*7 +: 7] != `RALS_RST_ADDR);
    end
  endgenerate

  // registered remap; address swapped before it leaves
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      fwd_req_o <= 1'b0;
      fwd_addr_o <= `RALS_RST_ADDR;
      fwd_port_o <= 1'b0;
    end else begin
      fwd_req_o <= |hit;
      if (hit[0]) begin
        fwd_addr_o <= target_tab_i[6:0];
        fwd_port_o <= 1'b0;
      end else if (hit[1]) begin
        fwd_addr_o <= target_tab_i[13:7];
        fwd_port_o <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ### rtl/rals_top.v
`timescale 1ns/1ps
`default_nettype none
`include "rals_regs.vh"
module rals_top (
  // clock and reset
  input wire ref_clk_i,
  input wire rst_n_i,
  // register access from the local i2c slave engine
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  // view selection
  input wire second_port_view_select_i,
  // local transaction address
  input wire loc_req_i,
  input wire [6:0] loc_addr_i,
  // toward the control channel
  output wire fwd_req_o,
  output wire [6:0] fwd_addr_o,
  output wire fwd_port_o,
  // link state per port
  input wire [1:0] link_detect_i,
  input wire [1:0] crc_err_i,
  input wire [1:0] bist_run_i,
  input wire [1:0] bist_start_i,
  // video input
  input wire video_input_clock_present_i
);

  // offsets that take writes
  wire hit_ctrl;
  wire hit_target;
  wire hit_alias;

  // write strobes; counter and status offsets get none, so writes there fall away
  wire wr_ctrl;
  wire wr_target;
  wire wr_alias;

  // view select and the port that a write lands in
  wire sel;
  wire [1:0] port_wr;

  // address tables for the remap engine, port 1 in the upper half
  wire [13:0] alias_tab;
  wire [13:0] target_tab;

  // per-port status from the health trackers
  wire [1:0] link_lost;
  wire [1:0] selftest_crc_error_flag;
  wire [1:0] des_err;

  // per-port read data, port 1 in the upper half
  wire [15:0] port_rdata;

  // read data of the viewed port
  reg [7:0] next_rdata;

  // decode the offset once for both ports
  assign hit_ctrl = (reg_addr_i == `RALS_OFS_CRC_CTRL);
  assign hit_target = (reg_addr_i == `RALS_OFS_TARGET);
  assign hit_alias = (reg_addr_i == `RALS_OFS_ALIAS);

  // only the stored registers accept a write
  assign wr_ctrl = reg_wr_i && hit_ctrl;
  assign wr_target = reg_wr_i && hit_target;
  assign wr_alias = reg_wr_i && hit_alias;

  // the pin picks the port the bus sees; the other copy is left alone
  assign sel = second_port_view_select_i;
  assign port_wr[0] = !sel;
  assign port_wr[1] = sel;

  // everything stored or tracked per link port
  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1) begin : g_port
      // stored fields of this port
      reg [6:0] target_q;
      reg [6:0] alias_q;
      reg crc_reset_q;

      // health state of this port
      wire [15:0] cnt;

      // read bytes of this port
      wire [7:0] ctrl_byte;
      wire [7:0] target_byte;
      wire [7:0] alias_byte;
      wire [7:0] status_byte;
      reg [7:0] port_rd;

      // remote target address; bit 0 is reserved and dropped
      always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
          target_q <= `RALS_RST_ADDR;
        end else if (wr_target && port_wr[p]) begin
          target_q <= reg_wdata_i[`RALS_ADDR_MSB:`RALS_ADDR_LSB];
        end
      end

      // local alias address; bit 0 is reserved and dropped
      always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
          alias_q <= `RALS_RST_ADDR;
        end else if (wr_alias && port_wr[p]) begin
          alias_q <= reg_wdata_i[`RALS_ADDR_MSB:`RALS_ADDR_LSB];
        end
      end

      // crc reset bit is stored so software can read it back
      always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
          crc_reset_q <= 1'b0;
        end else if (wr_ctrl && port_wr[p]) begin
          crc_reset_q <= reg_wdata_i[`RALS_CRC_RESET_BIT];
        end
      end

      // tables for the remap engine; it watches both ports whatever the view
      assign alias_tab[p*7 +: 7] = alias_q;
      assign target_tab[p*7 +: 7] = target_q;

      // clear holds while the bit stays set; software writes 0 to resume counting
      rals_port_status u_status (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .link_detect_i(link_detect_i[p]),
        .crc_err_i(crc_err_i[p]),
        .bist_run_i(bist_run_i[p]),
        .bist_start_i(bist_start_i[p]),
        .crc_clear_i(crc_reset_q),
        .crc_count_o(cnt),
        .link_lost_o(link_lost[p]),
        .selftest_err_o(selftest_crc_error_flag[p]),
        .des_err_o(des_err[p])
      );

      // address bytes: reserved bit 0 reads zero
      assign target_byte = {target_q, 1'b0};
      assign alias_byte = {alias_q, 1'b0};

      // control byte: only the crc reset bit is implemented
      assign ctrl_byte = {{(7 - `RALS_CRC_RESET_BIT){1'b0}}, crc_reset_q, {`RALS_CRC_RESET_BIT{1'b0}}};

      // status byte: live levels and sticky flags, reserved top bits zero
      assign status_byte[`RALS_ST_LINK_DETECT] = link_detect_i[p];
      assign status_byte[`RALS_ST_DES_ERROR] = des_err[p];
      assign status_byte[`RALS_ST_CLOCK_PRESENT] = video_input_clock_present_i;
      assign status_byte[`RALS_ST_SELFTEST_ERR] = selftest_crc_error_flag[p];
      assign status_byte[`RALS_ST_LINK_LOST] = link_lost[p];
      assign status_byte[7:`RALS_ST_LINK_LOST + 1] = 3'h0;

      // read mux of this port; unknown offsets give zero
      always @* begin
        port_rd = `RALS_RST_BYTE;
        case (reg_addr_i)
          `RALS_OFS_CRC_CTRL: begin
            port_rd = ctrl_byte;
          end
          `RALS_OFS_TARGET: begin
            port_rd = target_byte;
          end
          `RALS_OFS_ALIAS: begin
            port_rd = alias_byte;
          end
          `RALS_OFS_CRC_LOW: begin
            port_rd = cnt[7:0];
          end
          `RALS_OFS_CRC_HIGH: begin
            port_rd = cnt[15:8];
          end
          `RALS_OFS_STATUS: begin
            port_rd = status_byte;
          end
          default: begin
            port_rd = `RALS_RST_BYTE;
          end
        endcase
      end

      // hand the read byte up
      assign port_rdata[p*8 +: 8] = port_rd;
    end
  endgenerate

  // alias remap engine
  rals_alias_match u_match (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .alias_tab_i(alias_tab),
    .target_tab_i(target_tab),
    .loc_req_i(loc_req_i),
    .loc_addr_i(loc_addr_i),
    .fwd_req_o(fwd_req_o),
    .fwd_addr_o(fwd_addr_o),
    .fwd_port_o(fwd_port_o)
  );

  // the viewed port drives the bus; the other port's byte is ignored
  always @* begin
    next_rdata = `RALS_RST_BYTE;
    if (sel) begin
      next_rdata = port_rdata[15:8];
    end else begin
      next_rdata = port_rdata[7:0];
    end
  end

  // read data captured on the read strobe, held until the next one
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= `RALS_RST_BYTE;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end
  end

endmodule
`default_nettype wire

// ### dv/rals_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module rals_top_sva (
  // clock and reset
  input wire ref_clk_i,
  input wire rst_n_i,
  // register reads
  input wire reg_rd_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_rdata_o,
  input wire second_port_view_select_i,
  // alias path
  input wire loc_req_i,
  input wire [6:0] loc_addr_i,
  input wire fwd_req_o,
  input wire [6:0] fwd_addr_o,
  // live status inputs
  input wire [1:0] link_detect_i,
  input wire video_input_clock_present_i
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_fwd_cause:
    assert property (fwd_req_o |-> $past(loc_req_i)) else $error("forward without request");
  chk_fwd_nonzero:
    assert property (fwd_req_o |-> fwd_addr_o != 7'h00) else $error("forward to zero");
  chk_zero_alias:
    assert property (loc_req_i && loc_addr_i == 7'h00 |=> !fwd_req_o) else $error("zero hit");
  chk_status_resv:
    assert property (reg_rd_i && reg_addr_i == 8'h0C |=> reg_rdata_o[7:5] == 3'h0) else $error("status resv");
  chk_clock_bit:
    assert property (reg_rd_i && reg_addr_i == 8'h0C |=> reg_rdata_o[2] == $past(video_input_clock_present_i))
      else $error("clock bit");
  chk_link_bit:
    assert property (reg_rd_i && reg_addr_i == 8'h0C |=> reg_rdata_o[0] == ($past(second_port_view_select_i) ?
      $past(link_detect_i[1]) : $past(link_detect_i[0]))) else $error("link bit");
  chk_addr_lsb:
    assert property (reg_rd_i && reg_addr_i inside {8'h07, 8'h08} |=> !reg_rdata_o[0]) else $error("addr lsb");
  chk_unmapped_zero:
    assert property (reg_rd_i && reg_addr_i == 8'h00 |=> reg_rdata_o == 8'h00) else $error("unmapped");
  chk_ctrl_resv:
    assert property (reg_rd_i && reg_addr_i == 8'h04 |=> (reg_rdata_o & 8'hDF) == 8'h00) else $error("ctrl resv");
endmodule
bind rals_top rals_top_sva chk (.ref_clk_i, .rst_n_i, .reg_rd_i, .reg_addr_i, .reg_rdata_o,
  .second_port_view_select_i, .loc_req_i, .loc_addr_i, .fwd_req_o, .fwd_addr_o, .link_detect_i,
  .video_input_clock_present_i);
`default_nettype wire

// ### dv/rals_des_model.sv
`timescale 1ns/1ps
`default_nettype none
// far-side deserializer: link health events, counts forwarded hits
module rals_des_model (
  // clock
  input wire ref_clk_i,
  // forwarded traffic
  input wire fwd_req_i,
  // link health
  output logic [1:0] link_o,
  output logic [1:0] crc_o,
  output logic [1:0] bist_run_o,
  output logic [1:0] bist_start_o
);
  int hits = 0;
  // quiet link until the bench asks for events
  initial begin
    link_o = 2'h0;
    crc_o = 2'h0;
    bist_run_o = 2'h0;
    bist_start_o = 2'h0;
  end
  always @(posedge ref_clk_i) if (fwd_req_i) hits <= hits + 1;
  task automatic lvl(input logic [1:0] l, r);
    @(posedge ref_clk_i) #1;
    link_o = l;
    bist_run_o = r;
  endtask
  // gap lets a slow channel space its errors out
  task automatic errs(input int p, n, gap);
    repeat (n) begin
      @(posedge ref_clk_i) #1;
      crc_o[p] = 1'b1;
      @(posedge ref_clk_i) #1;
      crc_o[p] = 1'b0;
      repeat (gap) @(posedge ref_clk_i);
    end
  endtask
  task automatic restart(input int p);
    @(posedge ref_clk_i) #1;
    bist_start_o[p] = 1'b1;
    @(posedge ref_clk_i) #1;
    bist_start_o[p] = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### dv/rals_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module rals_top_tb_top;
  logic ref_clk_i, rst_n_i, reg_wr_i, reg_rd_i, sel, loc_req_i, vclk;
  logic [7:0] reg_addr_i, reg_wdata_i;
  logic [6:0] loc_addr_i;
  wire [7:0] reg_rdata_o;
  wire fwd_req_o, fwd_port_o;
  wire [6:0] fwd_addr_o;
  wire [1:0] lnk, crc, brun, bst;
  int failures = 0, compares = 0, cyc = 0;
  rals_top uut (.ref_clk_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
    .second_port_view_select_i(sel), .loc_req_i, .loc_addr_i, .fwd_req_o, .fwd_addr_o, .fwd_port_o,
    .link_detect_i(lnk), .crc_err_i(crc), .bist_run_i(brun), .bist_start_i(bst),
    .video_input_clock_present_i(vclk));
  rals_des_model des (.ref_clk_i, .fwd_req_i(fwd_req_o), .link_o(lnk), .crc_o(crc),
    .bist_run_o(brun), .bist_start_o(bst));
  task automatic summarize;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge ref_clk_i) #1;
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(posedge ref_clk_i) #1;
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input string n, input logic [7:0] a, exp);
    @(posedge ref_clk_i) #1;
    reg_rd_i = 1'b1;
    reg_addr_i = a;
    @(posedge ref_clk_i) #1;
    reg_rd_i = 1'b0;
    chk(n, reg_rdata_o, exp);
  endtask
  // e packs port and target as {port, addr}
  task automatic req(input logic [6:0] a, input logic h, input logic [7:0] e);
    @(posedge ref_clk_i) #1;
    loc_req_i = 1'b1;
    loc_addr_i = a;
    @(posedge ref_clk_i) #1;
    loc_req_i = 1'b0;
    chk("fwd_req", {7'h00, fwd_req_o}, {7'h00, h});
    if (h) chk("fwd_dst", {fwd_port_o, fwd_addr_o}, e);
  endtask
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // hang guard, far above the roughly 120 cycles needed
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    {rst_n_i, reg_wr_i, reg_rd_i, sel, loc_req_i, vclk} = 6'h00;
    {reg_addr_i, reg_wdata_i, loc_addr_i} = 23'h0;
    repeat (20) @(posedge ref_clk_i);
    #1 rst_n_i = 1'b1;
    rd("tgt", 8'h07, 8'h00);
    rd("unmapped", 8'h00, 8'h00);
    rd("status", 8'h0C, 8'h00);
    $display("reset test done");
    wr(8'h07, 8'h55);
    wr(8'h08, 8'h67);
    rd("tgt", 8'h07, 8'h54);
    req(7'h33, 1'b1, 8'h2A);
    req(7'h34, 1'b0, 8'h00);
    req(7'h00, 1'b0, 8'h00);
    sel = 1'b1;
    wr(8'h08, 8'h44);
    req(7'h22, 1'b0, 8'h00);
    wr(8'h07, 8'h20);
    req(7'h22, 1'b1, 8'h90);
    rd("tgt", 8'h07, 8'h20);
    sel = 1'b0;
    rd("tgt", 8'h07, 8'h54);
    chk("hits", des.hits[7:0], 8'h02);
    $display("alias test done");
    des.lvl(2'b01, 2'b00);
    des.errs(0, 3, 2);
    wr(8'h0A, 8'hFF);
    rd("crc_lo", 8'h0A, 8'h03);
    rd("crc_hi", 8'h0B, 8'h00);
    rd("status", 8'h0C, 8'h03);
    des.lvl(2'b01, 2'b01);
    des.errs(0, 1, 0);
    rd("status", 8'h0C, 8'h0B);
    des.restart(0);
    vclk = 1'b1;
    rd("status", 8'h0C, 8'h07);
    des.errs(1, 2, 0);
    sel = 1'b1;
    rd("crc_lo", 8'h0A, 8'h02);
    rd("status", 8'h0C, 8'h06);
    sel = 1'b0;
    rd("crc_lo", 8'h0A, 8'h04);
    $display("crc test done");
    des.errs(0, 1, 0);
    des.lvl(2'b00, 2'b00);
    rd("status", 8'h0C, 8'h14);
    rd("crc_lo", 8'h0A, 8'h05);
    wr(8'h04, 8'h20);
    rd("ctrl", 8'h04, 8'h20);
    rd("crc_lo", 8'h0A, 8'h00);
    rd("status", 8'h0C, 8'h04);
    wr(8'h04, 8'h00);
    des.errs(0, 1, 0);
    rd("crc_lo", 8'h0A, 8'h01);
    $display("loss test done");
    rst_n_i = 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1 rst_n_i = 1'b1;
    rd("tgt", 8'h07, 8'h00);
    rd("crc_lo", 8'h0A, 8'h00);
    rd("status", 8'h0C, 8'h04);
    $display("reset rerun done");
    summarize();
  end
endmodule
`default_nettype wire
